// ### common/port7_irq_pkg.sv
package port7_irq_pkg;
  // Register byte addresses.
  localparam logic [15:0] ADDR_EXT_IRQ23_CONTROL = 16'hfe5e;
  localparam logic [15:0] ADDR_INPUT_SIGNAL_SELECT = 16'hfe5f;
  localparam logic [15:0] ADDR_EVENT_STATUS = 16'hfe70;
  localparam logic [15:0] ADDR_EVENT_MASK = 16'hfe71;

  // Reset values.
  localparam logic [7:0] EXT_IRQ23_CONTROL_RESET = 8'h00;
  localparam logic [7:0] INPUT_SIGNAL_SELECT_RESET = 8'h00;
  localparam logic [3:0] EVENT_STATUS_RESET = 4'h0;
  localparam logic [3:0] EVENT_MASK_RESET = 4'h0;

  // Field positions of the interrupt 2/3 control register.
  localparam int IRQ3_RISE_ENABLE_BIT = 7;
  localparam int IRQ3_FALL_ENABLE_BIT = 6;
  localparam int IRQ3_SOURCE_FLAG_BIT = 5;
  localparam int IRQ3_REQUEST_ENABLE_BIT = 4;
  localparam int IRQ2_RISE_ENABLE_BIT = 3;
  localparam int IRQ2_FALL_ENABLE_BIT = 2;
  localparam int IRQ2_SOURCE_FLAG_BIT = 1;
  localparam int IRQ2_REQUEST_ENABLE_BIT = 0;

  // Field positions of the input signal select register.
  localparam int TIMER0_HIGH_CAPTURE_SOURCE_BIT = 7;
  localparam int TIMER0_LOW_CAPTURE_SOURCE_BIT = 6;
  localparam int BASE_TIMER_CLOCK_SEL_HI_BIT = 5;
  localparam int BASE_TIMER_CLOCK_SEL_LO_BIT = 4;
  localparam int BUZZER_OUTPUT_SELECT_BIT = 3;
  localparam int NOISE_FILTER_SEL_HI_BIT = 2;
  localparam int NOISE_FILTER_SEL_LO_BIT = 1;
  localparam int TIMER0_COUNT_SOURCE_BIT = 0;

  // Event status and mask bit positions.
  localparam int EVT_IRQ2_BIT = 0;
  localparam int EVT_IRQ3_BIT = 1;
  localparam int EVT_CAPTURE_HIGH_BIT = 2;
  localparam int EVT_CAPTURE_LOW_BIT = 3;

  // Noise filter time constants in cycles of the cycle clock.
  localparam int FILTER_LONG_TCYC = 128;
  localparam int FILTER_MID_TCYC = 32;
  localparam int FILTER_SHORT_TCYC = 1;
  localparam logic [7:0] FILTER_LONG_CYCLES = 8'(FILTER_LONG_TCYC);
  localparam logic [7:0] FILTER_MID_CYCLES = 8'(FILTER_MID_TCYC);
  localparam logic [7:0] FILTER_SHORT_CYCLES = 8'(FILTER_SHORT_TCYC);

  // Buzzer dividers; the output toggles every half period.
  localparam int BUZZER_DIV_WIDE = 16;
  localparam int BUZZER_DIV_NARROW = 8;
  localparam logic [3:0] BUZZER_HALF_WIDE = 4'(BUZZER_DIV_WIDE / 2 - 1);
  localparam logic [3:0] BUZZER_HALF_NARROW = 4'(BUZZER_DIV_NARROW / 2 - 1);

  // Interrupt vectors.
  localparam logic [15:0] IRQ2_VECTOR = 16'h0013;
  localparam logic [15:0] IRQ3_VECTOR = 16'h001b;
endpackage

// ### core/port7_ext_irq_input_select.sv
`timescale 1ns/1ns
module port7_ext_irq_input_select (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [3:0] port_pin_in,
  input wire logic [3:0] port_drive_req,
  input wire logic [3:0] port_oe_req,
  input wire logic [3:0] port_pullup_req,
  output logic [3:0] port_pin_out,
  output logic [3:0] port_pin_oe,
  output logic [3:0] port_pullup_en,
  input wire logic [1:0] irq0_mode,
  input wire logic [1:0] irq1_mode,
  input wire logic halt_mode,
  input wire logic hold_mode,
  input wire logic high_capture_taken_elsewhere,
  input wire logic low_capture_taken_elsewhere,
  input wire logic subclock_tick,
  input wire logic prescaler_tick,
  input wire logic shared_pin_function_select,
  input wire logic pwm_high_in,
  output logic timer1_pwm_high_output,
  output logic buzzer_pwm_pin,
  output logic base_timer_tick,
  output logic timer0_high_capture,
  output logic timer0_low_capture,
  output logic timer0_count_clock,
  output logic irq2_request,
  output logic irq3_request,
  output logic [15:0] irq_vector,
  output logic hold_release,
  output logic irq_out
);

  // Edge test for interrupts 2 and 3.
  function automatic logic edge_hit(input logic rise_en, input logic fall_en,
                                    input logic cur, input logic prev);
    edge_hit = (rise_en & cur & ~prev) | (fall_en & ~cur & prev);
  endfunction

  // Levels hit on every cycle.
  function automatic logic level_edge_hit(input logic [1:0] mode, input logic cur,
                                          input logic prev);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      2'b00: hit = ~cur & prev;
      2'b01: hit = ~cur;
      2'b10: hit = cur & ~prev;
      2'b11: hit = cur;
    endcase
    level_edge_hit = hit;
  endfunction

  // Storage.
  logic [7:0] irq23_ctrl_reg;
  logic [7:0] isl_reg;
  logic [3:0] evt_status_reg;
  logic [3:0] evt_mask_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] filt_reg;
  logic [3:0] filt_prev_reg;
  logic [7:0] filt_cnt_reg [4];
  logic hold_prev_reg;
  logic hold_ref_reg;
  logic [3:0] buz_cnt_reg;
  logic buzzer_reg;

  // Register decode.
  wire sel_ctrl = reg_addr == port7_irq_pkg::ADDR_EXT_IRQ23_CONTROL;
  wire sel_isl = reg_addr == port7_irq_pkg::ADDR_INPUT_SIGNAL_SELECT;
  wire sel_status = reg_addr == port7_irq_pkg::ADDR_EVENT_STATUS;
  wire sel_mask = reg_addr == port7_irq_pkg::ADDR_EVENT_MASK;
  wire wr_ctrl = reg_wr & sel_ctrl;
  wire wr_isl = reg_wr & sel_isl;
  wire wr_status = reg_wr & sel_status;
  wire wr_mask = reg_wr & sel_mask;

  // Control fields.
  wire irq3_rise_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ3_RISE_ENABLE_BIT];
  wire irq3_fall_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ3_FALL_ENABLE_BIT];
  wire irq3_source_flag = irq23_ctrl_reg[port7_irq_pkg::IRQ3_SOURCE_FLAG_BIT];
  wire irq3_request_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ3_REQUEST_ENABLE_BIT];
  wire irq2_rise_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ2_RISE_ENABLE_BIT];
  wire irq2_fall_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ2_FALL_ENABLE_BIT];
  wire irq2_source_flag = irq23_ctrl_reg[port7_irq_pkg::IRQ2_SOURCE_FLAG_BIT];
  wire irq2_request_enable = irq23_ctrl_reg[port7_irq_pkg::IRQ2_REQUEST_ENABLE_BIT];

  // Select fields.
  wire timer0_high_capture_source = isl_reg[port7_irq_pkg::TIMER0_HIGH_CAPTURE_SOURCE_BIT];
  wire timer0_low_capture_source = isl_reg[port7_irq_pkg::TIMER0_LOW_CAPTURE_SOURCE_BIT];
  wire [1:0] base_timer_clock_sel = {isl_reg[port7_irq_pkg::BASE_TIMER_CLOCK_SEL_HI_BIT],
                                     isl_reg[port7_irq_pkg::BASE_TIMER_CLOCK_SEL_LO_BIT]};
  wire buzzer_output_select = isl_reg[port7_irq_pkg::BUZZER_OUTPUT_SELECT_BIT];
  wire [1:0] noise_filter_sel = {isl_reg[port7_irq_pkg::NOISE_FILTER_SEL_HI_BIT],
                                 isl_reg[port7_irq_pkg::NOISE_FILTER_SEL_LO_BIT]};
  wire timer0_count_source = isl_reg[port7_irq_pkg::TIMER0_COUNT_SOURCE_BIT];

  // Noise filter: a pin change is accepted once it has stood for the chosen
  // number of cycles. Without a filter the synchronised level passes at once.
  logic [7:0] filter_limit;
  always_comb begin
    filter_limit = port7_irq_pkg::FILTER_SHORT_CYCLES;
    unique case (noise_filter_sel)
      2'b00: filter_limit = 8'h00;
      2'b01: filter_limit = port7_irq_pkg::FILTER_LONG_CYCLES;
      2'b10: filter_limit = port7_irq_pkg::FILTER_SHORT_CYCLES;
      2'b11: filter_limit = port7_irq_pkg::FILTER_MID_CYCLES;
    endcase
  end

  // A limit of one adds no delay beyond
  // the synchroniser.
  logic [3:0] filt_next;
  logic [7:0] filt_cnt_next [4];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      filt_next[i] = filt_reg[i];
      filt_cnt_next[i] = 8'h00;
      if (filter_limit == 8'h00) begin
        filt_next[i] = sync2_reg[i];
      end else if (sync2_reg[i] != filt_reg[i]) begin
        if (filt_cnt_reg[i] + 8'h01 >= filter_limit) begin
          filt_next[i] = sync2_reg[i];
        end else begin
          filt_cnt_next[i] = filt_cnt_reg[i] + 8'h01;
        end
      end
    end
  end

  // HOLD entry captures the third pin level so that edges back toward it are
  // not taken as wake-ups; the entry cycle itself uses the live level.
  wire hold_entry = hold_mode & ~hold_prev_reg;
  wire hold_ref = hold_entry ? filt_reg[2] : hold_ref_reg;
  wire irq2_rise_block = hold_mode & hold_ref;
  wire irq2_fall_block = hold_mode & ~hold_ref;

  // Pin conditions.
  wire irq0_hit = level_edge_hit(irq0_mode, filt_reg[0], filt_prev_reg[0]);
  wire irq1_hit = level_edge_hit(irq1_mode, filt_reg[1], filt_prev_reg[1]);
  wire irq2_hit = edge_hit(irq2_rise_enable & ~irq2_rise_block,
                           irq2_fall_enable & ~irq2_fall_block,
                           filt_reg[2], filt_prev_reg[2]);
  wire irq3_hit = edge_hit(irq3_rise_enable, irq3_fall_enable,
                           filt_reg[3], filt_prev_reg[3]);
  // Routing ignores the HOLD block.
  wire irq2_cond = edge_hit(irq2_rise_enable, irq2_fall_enable, filt_reg[2], filt_prev_reg[2]);

  // Timer 0 routing.
  wire high_cap_raw = timer0_high_capture_source ? irq1_hit : irq3_hit;
  wire low_cap_raw = timer0_low_capture_source ? irq0_hit : irq2_cond;
  wire high_cap_next = high_cap_raw & ~high_capture_taken_elsewhere;
  wire low_cap_next = low_cap_raw & ~low_capture_taken_elsewhere;
  wire count_next = timer0_count_source ? irq3_hit : irq2_cond;

  // Source flags: an event outweighs a clear written in the same cycle.
  wire irq3_flag_next = irq3_hit | (wr_ctrl ?
    reg_wdata[port7_irq_pkg::IRQ3_SOURCE_FLAG_BIT] : irq3_source_flag);
  wire irq2_flag_next = irq2_hit | (wr_ctrl ?
    reg_wdata[port7_irq_pkg::IRQ2_SOURCE_FLAG_BIT] : irq2_source_flag);

  logic [7:0] irq23_ctrl_next;
  always_comb begin
    irq23_ctrl_next = wr_ctrl ? reg_wdata : irq23_ctrl_reg;
    irq23_ctrl_next[port7_irq_pkg::IRQ3_SOURCE_FLAG_BIT] = irq3_flag_next;
    irq23_ctrl_next[port7_irq_pkg::IRQ2_SOURCE_FLAG_BIT] = irq2_flag_next;
  end

  // Requests follow the stored flag and enable.
  wire irq3_req_next = irq3_flag_next & irq23_ctrl_next[port7_irq_pkg::IRQ3_REQUEST_ENABLE_BIT];
  wire irq2_req_next = irq2_flag_next & irq23_ctrl_next[port7_irq_pkg::IRQ2_REQUEST_ENABLE_BIT];
  // Interrupt 2 has the lower vector and so the higher priority here.
  wire [15:0] vector_next = irq2_req_next ? port7_irq_pkg::IRQ2_VECTOR :
                            irq3_req_next ? port7_irq_pkg::IRQ3_VECTOR : 16'h0000;

  // Event status: sticky, cleared by writing one, a fresh event wins.
  logic [3:0] evt_set;
  always_comb begin
    evt_set = 4'h0;
    evt_set[port7_irq_pkg::EVT_IRQ2_BIT] = irq2_hit;
    evt_set[port7_irq_pkg::EVT_IRQ3_BIT] = irq3_hit;
    evt_set[port7_irq_pkg::EVT_CAPTURE_HIGH_BIT] = high_cap_next;
    evt_set[port7_irq_pkg::EVT_CAPTURE_LOW_BIT] = low_cap_next;
  end
  wire [3:0] evt_clear = wr_status ? reg_wdata[3:0] : 4'h0;
  wire [3:0] evt_status_next = evt_set | (evt_status_reg & ~evt_clear);
  wire [3:0] evt_mask_next = wr_mask ? reg_wdata[3:0] : evt_mask_reg;

  // Base timer clock and buzzer divider.
  // A cycle clock tick is always high.
  logic sel_tick;
  always_comb begin
    sel_tick = subclock_tick;
    unique case (base_timer_clock_sel)
      2'b00: sel_tick = subclock_tick;
      2'b01: sel_tick = 1'b1;
      2'b10: sel_tick = subclock_tick;
      2'b11: sel_tick = prescaler_tick;
    endcase
  end
  wire [3:0] buz_half = (base_timer_clock_sel == 2'b10) ?
                        port7_irq_pkg::BUZZER_HALF_NARROW : port7_irq_pkg::BUZZER_HALF_WIDE;
  // Each wrap toggles the buzzer.
  wire buz_wrap = sel_tick & (buz_cnt_reg >= buz_half);
  wire [3:0] buz_cnt_next = ~sel_tick ? buz_cnt_reg : buz_wrap ? 4'h0 : buz_cnt_reg + 4'h1;
  wire buzzer_next = buz_wrap ? ~buzzer_reg : buzzer_reg;

  // Shared pin selection; the unselected source is held high.
  wire pwm_out_next = (shared_pin_function_select & buzzer_output_select) ? 1'b1
                      : pwm_high_in;
  wire buz_pin_next = ~shared_pin_function_select ? 1'b1 :
                      buzzer_output_select ? buzzer_reg : pwm_high_in;

  // Low power freezes the upper three pins and drops the first pull-up.
  wire low_power = halt_mode | hold_mode;
  wire [3:0] pin_out_next = low_power ? {port_pin_out[3:1], port_drive_req[0]}
                            : port_drive_req;
  wire [3:0] pin_oe_next = low_power ? {port_pin_oe[3:1], port_oe_req[0]} : port_oe_req;
  wire [3:0] pullup_next = low_power ? {port_pullup_en[3:1], 1'b0} : port_pullup_req;

  // Read data for the following cycle; unmapped addresses read zero.
  wire [7:0] rdata_next = ~reg_rd ? 8'h00 :
                          sel_ctrl ? irq23_ctrl_reg :
                          sel_isl ? isl_reg :
                          sel_status ? {4'h0, evt_status_reg} :
                          sel_mask ? {4'h0, evt_mask_reg} : 8'h00;

  // Pin synchroniser.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= port_pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Filtered level and its last value.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 4'h0;
      filt_prev_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        filt_cnt_reg[i] <= 8'h00;
      end
    end else begin
      filt_reg <= filt_next;
      filt_prev_reg <= filt_reg;
      for (int i = 0; i < 4; i++) begin
        filt_cnt_reg[i] <= filt_cnt_next[i];
      end
    end
  end

  // HOLD entry reference.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_prev_reg <= 1'b0;
      hold_ref_reg <= 1'b0;
    end else begin
      hold_prev_reg <= hold_mode;
      hold_ref_reg <= hold_ref;
    end
  end

  // Software registers and read data.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq23_ctrl_reg <= port7_irq_pkg::EXT_IRQ23_CONTROL_RESET;
      isl_reg <= port7_irq_pkg::INPUT_SIGNAL_SELECT_RESET;
      evt_status_reg <= port7_irq_pkg::EVENT_STATUS_RESET;
      evt_mask_reg <= port7_irq_pkg::EVENT_MASK_RESET;
      reg_rdata <= 8'h00;
    end else begin
      irq23_ctrl_reg <= irq23_ctrl_next;
      isl_reg <= wr_isl ? reg_wdata : isl_reg;
      evt_status_reg <= evt_status_next;
      evt_mask_reg <= evt_mask_next;
      reg_rdata <= rdata_next;
    end
  end

  // Requests use next flag values so that
  // they move with the stored flags.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq2_request <= 1'b0;
      irq3_request <= 1'b0;
      irq_vector <= 16'h0000;
      hold_release <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      irq2_request <= irq2_req_next;
      irq3_request <= irq3_req_next;
      irq_vector <= vector_next;
      hold_release <= irq2_req_next | irq3_req_next;
      irq_out <= |(evt_status_next & evt_mask_next);
    end
  end

  // One registered pulse per hit; a level condition pulses on every cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_high_capture <= 1'b0;
      timer0_low_capture <= 1'b0;
      timer0_count_clock <= 1'b0;
    end else begin
      timer0_high_capture <= high_cap_next;
      timer0_low_capture <= low_cap_next;
      timer0_count_clock <= count_next;
    end
  end

  // The buzzer rests high.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buz_cnt_reg <= 4'h0;
      buzzer_reg <= 1'b1;
      base_timer_tick <= 1'b0;
      timer1_pwm_high_output <= 1'b1;
      buzzer_pwm_pin <= 1'b1;
    end else begin
      buz_cnt_reg <= buz_cnt_next;
      buzzer_reg <= buzzer_next;
      base_timer_tick <= sel_tick;
      timer1_pwm_high_output <= pwm_out_next;
      buzzer_pwm_pin <= buz_pin_next;
    end
  end

  // Pin controls, registered.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_pin_out <= 4'h0;
      port_pin_oe <= 4'h0;
      port_pullup_en <= 4'h0;
    end else begin
      port_pin_out <= pin_out_next;
      port_pin_oe <= pin_oe_next;
      port_pullup_en <= pullup_next;
    end
  end

endmodule

// ### verification/port7_ext_irq_input_select_bench.sv
`timescale 1ns/1ns
module port7_ext_irq_input_select_bench;
  localparam logic [15:0] A_CTL = port7_irq_pkg::ADDR_EXT_IRQ23_CONTROL;
  localparam logic [15:0] A_SEL = port7_irq_pkg::ADDR_INPUT_SIGNAL_SELECT;
  localparam logic [15:0] A_STS = port7_irq_pkg::ADDR_EVENT_STATUS;
  localparam logic [15:0] A_MSK = port7_irq_pkg::ADDR_EVENT_MASK;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] port_pin_in = 4'h0;
  logic [3:0] port_drive_req = 4'h0;
  logic [3:0] port_oe_req = 4'h0;
  logic [3:0] port_pullup_req = 4'hf;
  logic [1:0] irq0_mode = 2'b00;
  logic [1:0] irq1_mode = 2'b00;
  logic halt_mode = 1'b0;
  logic hold_mode = 1'b0;
  logic high_capture_taken_elsewhere = 1'b0;
  logic low_capture_taken_elsewhere = 1'b0;
  logic shared_pin_function_select = 1'b0;
  logic subclock_tick, prescaler_tick, pwm_high_in, timer1_pwm_high_output, buzzer_pwm_pin;
  logic base_timer_tick, timer0_high_capture, timer0_low_capture, timer0_count_clock;
  logic irq2_request, irq3_request, hold_release, irq_out;
  logic [7:0] reg_rdata;
  logic [3:0] port_pin_out, port_pin_oe, port_pullup_en;
  logic [15:0] irq_vector;
  logic buz_prev = 1'b1;
  logic [15:0] regs [4] = '{A_CTL, A_SEL, A_STS, A_MSK};
  int seed = 16;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_hi = 0, n_lo = 0, n_cnt = 0, n_tick = 0, n_buz = 0;
  port7_ext_irq_input_select dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .port_pin_in, .port_drive_req, .port_oe_req, .port_pullup_req, .port_pin_out,
    .port_pin_oe, .port_pullup_en, .irq0_mode, .irq1_mode, .halt_mode, .hold_mode,
    .high_capture_taken_elsewhere, .low_capture_taken_elsewhere, .subclock_tick,
    .prescaler_tick, .shared_pin_function_select, .pwm_high_in, .timer1_pwm_high_output,
    .buzzer_pwm_pin, .base_timer_tick, .timer0_high_capture, .timer0_low_capture,
    .timer0_count_clock, .irq2_request, .irq3_request, .irq_vector, .hold_release, .irq_out);
  tick_source_model src_u (.mclk, .rst_n, .subclock_tick, .prescaler_tick, .pwm_high_in);
  always #5 mclk = ~mclk;
  // Counters update by non-blocking assignment so that reads at an edge never race them.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    n_hi <= n_hi + int'(timer0_high_capture);
    n_lo <= n_lo + int'(timer0_low_capture);
    n_cnt <= n_cnt + int'(timer0_count_clock);
    n_tick <= n_tick + int'(base_timer_tick);
    n_buz <= n_buz + int'(buzzer_pwm_pin !== buz_prev);
    buz_prev <= buzzer_pwm_pin;
    port_drive_req <= 4'($random(seed));
    port_oe_req <= 4'($random(seed));
    port_pullup_req <= 4'($random(seed));
    if (cycles == 12000) begin
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic logic edge_hit(input logic [1:0] mode, input logic rising);
    return rising ? mode[1] : mode[0];
  endfunction
  function automatic int tick_period(input int s);
    return (s == 1) ? 1 : (s == 3) ? 2 : 4;
  endfunction
  function automatic int buzz_toggles(input int s, input int win);
    return win / (tick_period(s) * ((s == 2) ? 8 : 16) / 2);
  endfunction
  task automatic edge_case(input int p, input logic [1:0] mode);
    logic [7:0] v;
    int sh, c0, h0;
    logic exp;
    sh = (p == 3) ? 4 : 0;
    exp = 1'b0;
    wr(A_SEL, (p == 3) ? 8'h01 : 8'h00);
    wr(A_CTL, 8'({4'h0, mode, 2'b01}) << sh);
    for (int e = 1; e >= 0; e--) begin
      c0 = n_cnt;
      h0 = n_hi + n_lo;
      @(posedge mclk);
      port_pin_in[p] <= e[0];
      tick(10 + ($random(seed) & 7));
      exp = exp | edge_hit(mode, e[0]);
      rd(A_CTL, v);
      chk(16'(v[sh + 1]), 16'(exp), "source flag");
      chk(16'(hold_release), 16'(exp), "hold release");
      chk(16'(n_cnt - c0), 16'(edge_hit(mode, e[0])), "count pulses");
      chk(16'(n_hi + n_lo - h0), 16'(edge_hit(mode, e[0])), "capture pulses");
    end
  endtask
  initial begin
    logic [7:0] v;
    logic [7:0] r;
    int c, l, d;
    tick(4);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i], v);
      chk(16'(v), 16'h0000, "reset value");
    end
    wr(16'hfe60, 8'hff);
    rd(16'hfe60, v);
    chk(16'(v), 16'h0000, "unmapped read");
    r = 8'($random(seed));
    wr(A_SEL, r);
    rd(A_SEL, v);
    chk(16'(v), 16'(r), "select readback");
    for (int p = 2; p < 4; p++) for (int m = 0; m < 4; m++) edge_case(p, 2'(m));
    for (int f = 0; f < 4; f++) begin
      wr(A_SEL, {5'h00, 2'(f), 1'b0});
      wr(A_CTL, 8'h90);
      port_pin_in[3] <= 1'b1;
      tick(60);
      port_pin_in[3] <= 1'b0;
      tick(140);
      rd(A_CTL, v);
      chk(16'(v[5]), 16'(f != 1), "filtered edge");
    end
    wr(A_SEL, 8'h00);
    wr(A_STS, 8'h0f);
    wr(A_MSK, 8'h00);
    port_pin_in[3] <= 1'b1;
    tick(10);
    rd(A_STS, v);
    chk(16'({v[1], irq_out}), 16'h0002, "masked status");
    wr(A_MSK, 8'h02);
    tick(2);
    chk(16'(irq_out), 16'h0001, "unmasked event");
    wr(A_STS, 8'h02);
    tick(2);
    chk(16'(irq_out), 16'h0000, "status cleared");
    port_pin_in[3] <= 1'b0;
    wr(A_CTL, 8'h33);
    tick(2);
    chk(irq_vector, port7_irq_pkg::IRQ2_VECTOR, "both pending");
    wr(A_CTL, 8'h30);
    tick(2);
    chk(irq_vector, port7_irq_pkg::IRQ3_VECTOR, "third pending");
    wr(A_CTL, 8'h00);
    wr(A_SEL, 8'hc0);
    irq1_mode <= 2'b11;
    irq0_mode <= 2'b01;
    port_pin_in[1:0] <= 2'b10;
    tick(8);
    c = n_hi;
    l = n_lo;
    tick(20);
    chk(16'(n_hi - c), 16'd20, "high level capture");
    chk(16'(n_lo - l), 16'd20, "low level capture");
    high_capture_taken_elsewhere <= 1'b1;
    low_capture_taken_elsewhere <= 1'b1;
    tick(4);
    c = n_hi + n_lo;
    tick(20);
    chk(16'(n_hi + n_lo - c), 16'd0, "captures taken elsewhere");
    high_capture_taken_elsewhere <= 1'b0;
    low_capture_taken_elsewhere <= 1'b0;
    port_pin_in[1:0] <= 2'b00;
    wr(A_SEL, 8'h00);
    wr(A_CTL, 8'h05);
    hold_mode <= 1'b1;
    tick(4);
    l = int'(port_pin_oe[3:1]);
    port_pin_in[2] <= 1'b1;
    tick(10);
    port_pin_in[2] <= 1'b0;
    tick(10);
    rd(A_CTL, v);
    chk(16'(v[1]), 16'h0000, "edge toward entry level");
    chk(16'(port_pullup_en[0]), 16'h0000, "first pull-up in hold");
    chk(16'(port_pin_oe[3:1]), 16'(l), "oe held in hold");
    wr(A_CTL, 8'h0d);
    port_pin_in[2] <= 1'b1;
    tick(10);
    chk(16'(hold_release), 16'h0001, "both-edge wake");
    hold_mode <= 1'b0;
    halt_mode <= 1'b1;
    port_pin_in[2] <= 1'b0;
    tick(4);
    chk(16'(port_pullup_en[0]), 16'h0000, "first pull-up in halt");
    halt_mode <= 1'b0;
    wr(A_CTL, 8'h00);
    shared_pin_function_select <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(A_SEL, {2'b00, 2'(s), 4'h8});
      tick(40);
      c = n_buz;
      l = n_tick;
      tick(256);
      d = n_buz - c - buzz_toggles(s, 256);
      chk(16'(d >= -1 && d <= 1), 16'h0001, "buzzer rate");
      chk(16'(n_tick - l), 16'(256 / tick_period(s)), "base timer ticks");
      chk(16'(timer1_pwm_high_output), 16'h0001, "pwm held high");
    end
    wr(A_SEL, 8'h00);
    tick(10);
    c = n_buz;
    tick(128);
    d = n_buz - c;
    chk(16'(d >= 15 && d <= 17), 16'h0001, "pwm on shared pin");
    shared_pin_function_select <= 1'b0;
    tick(3);
    chk(16'(buzzer_pwm_pin), 16'h0001, "shared pin idle");
    wrap_up();
  end
endmodule

// ### verification/port7_irq_props.sv
`timescale 1ns/1ns
module port7_irq_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [3:0] port_pin_in,
  input wire logic [3:0] port_pin_out,
  input wire logic [3:0] port_pullup_en,
  input wire logic [1:0] irq1_mode,
  input wire logic halt_mode,
  input wire logic hold_mode,
  input wire logic high_capture_taken_elsewhere,
  input wire logic shared_pin_function_select,
  input wire logic buzzer_pwm_pin,
  input wire logic timer0_high_capture,
  input wire logic irq2_request,
  input wire logic irq3_request,
  input wire logic [15:0] irq_vector,
  input wire logic hold_release
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Each written byte is shadowed whole, flag bits included; the hardware-set flags are not tracked.
  logic [7:0] ctl_shadow_reg;
  logic [7:0] sel_shadow_reg;
  wire ctl_write = reg_wr && (reg_addr == port7_irq_pkg::ADDR_EXT_IRQ23_CONTROL);
  wire sel_write = reg_wr && (reg_addr == port7_irq_pkg::ADDR_INPUT_SIGNAL_SELECT);
  wire asleep = halt_mode || hold_mode;
  wire quiet3 = (ctl_shadow_reg[7:6] == 2'b00) && !ctl_write;
  wire level_high = sel_shadow_reg[7] && (sel_shadow_reg[2:1] == 2'b00)
    && (irq1_mode == 2'b11) && port_pin_in[1] && !high_capture_taken_elsewhere;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_shadow_reg <= port7_irq_pkg::EXT_IRQ23_CONTROL_RESET;
      sel_shadow_reg <= port7_irq_pkg::INPUT_SIGNAL_SELECT_RESET;
    end else begin
      if (ctl_write) ctl_shadow_reg <= reg_wdata;
      if (sel_write) sel_shadow_reg <= reg_wdata;
    end
  end
  hold_release_a: assert property (hold_release == (irq2_request || irq3_request))
    else $error("hold release differs from the requests");
  vector_two_a: assert property (irq2_request |-> irq_vector == port7_irq_pkg::IRQ2_VECTOR)
    else $error("vector wrong for interrupt 2");
  vector_three_a: assert property (
    irq3_request && !irq2_request |-> irq_vector == port7_irq_pkg::IRQ3_VECTOR)
    else $error("vector wrong for interrupt 3");
  no_edge_a: assert property (quiet3 [*6] |-> !$rose(irq3_request))
    else $error("interrupt 3 request rose with detection off");
  level_capture_a: assert property (level_high [*6] |-> timer0_high_capture)
    else $error("level capture missing in a cycle");
  capture_ignored_a: assert property (
    high_capture_taken_elsewhere && $past(high_capture_taken_elsewhere) |-> !timer0_high_capture)
    else $error("port capture not ignored");
  pullup_off_a: assert property (asleep && $past(asleep) |-> !port_pullup_en[0])
    else $error("first pin pull-up on while asleep");
  pin_freeze_a: assert property (
    hold_mode && $past(hold_mode) && $past(hold_mode, 2) |-> $stable(port_pin_out[3:1]))
    else $error("pins moved during hold");
  pwm_idle_a: assert property (
    !shared_pin_function_select && !$past(shared_pin_function_select) |-> buzzer_pwm_pin)
    else $error("shared pin not high while unrouted");
  cover property (level_high [*6]);
  cover property (irq2_request && irq3_request);
  cover property ($rose(irq3_request));
endmodule
bind port7_ext_irq_input_select port7_irq_props props_u (.mclk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .port_pin_in, .port_pin_out, .port_pullup_en, .irq1_mode, .halt_mode,
  .hold_mode, .high_capture_taken_elsewhere, .shared_pin_function_select, .buzzer_pwm_pin,
  .timer0_high_capture, .irq2_request, .irq3_request, .irq_vector, .hold_release);

// ### verification/tick_source_model.sv
`timescale 1ns/1ns
// Far side: subclock every 4 cycles, prescaler every 2, timer 1 PWM toggling every 8.
module tick_source_model (
  input wire logic mclk,
  input wire logic rst_n,
  output logic subclock_tick,
  output logic prescaler_tick,
  output logic pwm_high_in
);
  logic [2:0] phase_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 3'h0;
      subclock_tick <= 1'b0;
      prescaler_tick <= 1'b0;
      pwm_high_in <= 1'b0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
      subclock_tick <= (phase_reg[1:0] == 2'h2);
      prescaler_tick <= phase_reg[0];
      pwm_high_in <= pwm_high_in ^ (phase_reg == 3'h7);
    end
  end
endmodule
